// ---- design/arfwd_pkg.sv ----
// Package for the result formatter and window detector.
// Holds register addresses, field positions, reset values and widths.
// Assumes an 8-bit special-function-register bus with byte addresses.
package arfwd_pkg;

  // Widths
  localparam int unsigned CODE_W = 12;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NIBBLE_W = 4;

  // Register addresses on the special-function-register bus
  localparam logic [7:0] ADDR_CONTROL = 8'hE8;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBF;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hBE;
  localparam logic [7:0] ADDR_UPPER_LIMIT_LOW = 8'hC4;
  localparam logic [7:0] ADDR_UPPER_LIMIT_HIGH = 8'hC5;
  localparam logic [7:0] ADDR_LOWER_LIMIT_LOW = 8'hC6;
  localparam logic [7:0] ADDR_LOWER_LIMIT_HIGH = 8'hC7;

  // Control register field positions
  localparam int unsigned BIT_LEFT_JUSTIFY = 0;
  localparam int unsigned BIT_WINDOW_FLAG = 1;

  // Reset values
  localparam logic [7:0] RST_UPPER_LIMIT = 8'hFF;
  localparam logic [7:0] RST_LOWER_LIMIT = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic RST_LEFT_JUSTIFY = 1'b0;
  localparam logic RST_WINDOW_FLAG = 1'b0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Fill patterns
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

endpackage

// ---- design/arfwd_fmt_if.sv ----
// Interface between the register block and the formatter/comparator.
// Assumes both ends sit on the same clock; all signals are combinational.
`timescale 1ns/100ps
interface arfwd_fmt_if;
  logic [arfwd_pkg::CODE_W-1:0] code;
  logic differential;
  logic left_justify;
  logic [arfwd_pkg::WORD_W-1:0] upper_limit;
  logic [arfwd_pkg::WORD_W-1:0] lower_limit;
  logic [arfwd_pkg::WORD_W-1:0] word;
  logic hit;

  // Formatter end
  modport fmt (
    input code, differential, left_justify, upper_limit, lower_limit,
    output word, hit
  );

  // Register-block end
  modport ctl (
    output code, differential, left_justify, upper_limit, lower_limit,
    input word, hit
  );
endinterface

// ---- design/arfwd_fmt.sv ----
// Result formatter and window comparator, purely combinational.
// Assumes the caller supplies a captured code and the current limits.
`timescale 1ns/100ps
module arfwd_fmt (
  // Link to the register block
  arfwd_fmt_if.fmt link
);

  logic outside_mode;
  logic below_lower;
  logic above_upper;

  // Ordered compare, signed for differential data
  function automatic logic word_less(
    input logic [arfwd_pkg::WORD_W-1:0] a,
    input logic [arfwd_pkg::WORD_W-1:0] b,
    input logic signed_mode
  );
    if (signed_mode)
    begin
      word_less = ($signed(a) < $signed(b));
    end
    else
    begin
      word_less = (a < b);
    end
  endfunction

  // Place the code in the 16-bit result word
  always_comb
  begin
    if (link.left_justify)
    begin
      link.word = {link.code, arfwd_pkg::NIBBLE_ZERO};
    end
    else if (link.differential)
    begin
      link.word = {{arfwd_pkg::NIBBLE_W{link.code[arfwd_pkg::CODE_W-1]}}, link.code};
    end
    else
    begin
      link.word = {arfwd_pkg::NIBBLE_ZERO, link.code};
    end
  end

  // Window test on the word as it will be stored
  always_comb
  begin
    below_lower = word_less(link.word, link.lower_limit, link.differential);
    above_upper = word_less(link.upper_limit, link.word, link.differential);
    outside_mode = !word_less(link.upper_limit, link.lower_limit, link.differential);
    if (outside_mode)
    begin
      link.hit = below_lower || above_upper;
    end
    else
    begin
      link.hit = below_lower && above_upper;
    end
  end

endmodule // arfwd_fmt

// ---- design/arfwd_top.sv ----
// Top of the result formatter and window detector.
// Assumes the converter end-of-conversion pulse, code and differential
// indication come from logic on mclk_i, so they are not synchronised.
// Assumes a simple special-function-register bus with one-cycle strobes.
`timescale 1ns/100ps
module arfwd_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Special-function-register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // Converter side
  input wire logic conv_done_i,
  input wire logic [arfwd_pkg::CODE_W-1:0] conv_code_i,
  input wire logic conv_differential_i,
  // Status out
  output logic window_compare_flag_o,
  output logic result_left_justify_o
);

  // Control state
  logic result_left_justify;
  logic next_result_left_justify;
  logic window_compare_flag;
  logic next_window_compare_flag;

  // Limit bytes
  logic [7:0] window_upper_limit_low;
  logic [7:0] next_window_upper_limit_low;
  logic [7:0] window_upper_limit_high;
  logic [7:0] next_window_upper_limit_high;
  logic [7:0] window_lower_limit_low;
  logic [7:0] next_window_lower_limit_low;
  logic [7:0] window_lower_limit_high;
  logic [7:0] next_window_lower_limit_high;

  // Result bytes
  logic [7:0] result_high_byte;
  logic [7:0] next_result_high_byte;
  logic [7:0] result_low_byte;
  logic [7:0] next_result_low_byte;

  // Capture stage between the converter and the result registers
  logic cap_valid;
  logic next_cap_valid;
  logic [arfwd_pkg::CODE_W-1:0] cap_code;
  logic [arfwd_pkg::CODE_W-1:0] next_cap_code;
  logic cap_differential;
  logic next_cap_differential;

  // Read data and status outputs
  logic [7:0] next_sfr_rdata;
  logic next_window_compare_flag_o;
  logic next_result_left_justify_o;

  // Decoded write strobes
  logic wr_control;
  logic wr_upper_low;
  logic wr_upper_high;
  logic wr_lower_low;
  logic wr_lower_high;
  logic wr_result_high;
  logic wr_result_low;

  // Formatter link
  arfwd_fmt_if fmt_link ();

  // True when a write strobe targets the given address
  function automatic logic write_to(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    write_to = strobe && (addr == target);
  endfunction

  // Formatter and window comparator
  arfwd_fmt u_fmt (
    .link(fmt_link)
  );

  // Drive the formatter from the captured conversion and current limits
  assign fmt_link.code = cap_code;
  assign fmt_link.differential = cap_differential;
  assign fmt_link.left_justify = result_left_justify;
  assign fmt_link.upper_limit = {window_upper_limit_high, window_upper_limit_low};
  assign fmt_link.lower_limit = {window_lower_limit_high, window_lower_limit_low};

  // Write address decode
  always_comb
  begin
    wr_control = write_to(sfr_wr_i, sfr_addr_i, arfwd_pkg::ADDR_CONTROL);
    wr_upper_low = write_to(sfr_wr_i, sfr_addr_i, arfwd_pkg::ADDR_UPPER_LIMIT_LOW);
    wr_upper_high = write_to(sfr_wr_i, sfr_addr_i, arfwd_pkg::ADDR_UPPER_LIMIT_HIGH);
    wr_lower_low = write_to(sfr_wr_i, sfr_addr_i, arfwd_pkg::ADDR_LOWER_LIMIT_LOW);
    wr_lower_high = write_to(sfr_wr_i, sfr_addr_i, arfwd_pkg::ADDR_LOWER_LIMIT_HIGH);
    wr_result_high = write_to(sfr_wr_i, sfr_addr_i, arfwd_pkg::ADDR_RESULT_HIGH);
    wr_result_low = write_to(sfr_wr_i, sfr_addr_i, arfwd_pkg::ADDR_RESULT_LOW);
  end

  // Capture stage: hold one finished conversion for formatting
  always_comb
  begin
    next_cap_valid = conv_done_i;
    next_cap_code = cap_code;
    next_cap_differential = cap_differential;
    if (conv_done_i)
    begin
      next_cap_code = conv_code_i;
      next_cap_differential = conv_differential_i;
    end
  end

  // Capture stage registers
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cap_valid <= 1'b0;
      cap_code <= '0;
      cap_differential <= 1'b0;
    end
    else
    begin
      cap_valid <= next_cap_valid;
      cap_code <= next_cap_code;
      cap_differential <= next_cap_differential;
    end
  end

  // Control register: justify select and window flag
  always_comb
  begin
    next_result_left_justify = result_left_justify;
    next_window_compare_flag = window_compare_flag;
    if (wr_control)
    begin
      next_result_left_justify = sfr_wdata_i[arfwd_pkg::BIT_LEFT_JUSTIFY];
      next_window_compare_flag = sfr_wdata_i[arfwd_pkg::BIT_WINDOW_FLAG];
    end
    // A match in the same cycle as a software clear keeps the flag set
    if (cap_valid && fmt_link.hit)
    begin
      next_window_compare_flag = 1'b1;
    end
  end

  // Control register state
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      result_left_justify <= arfwd_pkg::RST_LEFT_JUSTIFY;
      window_compare_flag <= arfwd_pkg::RST_WINDOW_FLAG;
    end
    else
    begin
      result_left_justify <= next_result_left_justify;
      window_compare_flag <= next_window_compare_flag;
    end
  end

  // Limit bytes, each written on its own address
  always_comb
  begin
    next_window_upper_limit_low = window_upper_limit_low;
    next_window_upper_limit_high = window_upper_limit_high;
    next_window_lower_limit_low = window_lower_limit_low;
    next_window_lower_limit_high = window_lower_limit_high;
    if (wr_upper_low)
    begin
      next_window_upper_limit_low = sfr_wdata_i;
    end
    if (wr_upper_high)
    begin
      next_window_upper_limit_high = sfr_wdata_i;
    end
    if (wr_lower_low)
    begin
      next_window_lower_limit_low = sfr_wdata_i;
    end
    if (wr_lower_high)
    begin
      next_window_lower_limit_high = sfr_wdata_i;
    end
  end

  // Limit byte state
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      window_upper_limit_low <= arfwd_pkg::RST_UPPER_LIMIT;
      window_upper_limit_high <= arfwd_pkg::RST_UPPER_LIMIT;
      window_lower_limit_low <= arfwd_pkg::RST_LOWER_LIMIT;
      window_lower_limit_high <= arfwd_pkg::RST_LOWER_LIMIT;
    end
    else
    begin
      window_upper_limit_low <= next_window_upper_limit_low;
      window_upper_limit_high <= next_window_upper_limit_high;
      window_lower_limit_low <= next_window_lower_limit_low;
      window_lower_limit_high <= next_window_lower_limit_high;
    end
  end

  // Result bytes: a finished conversion wins over a software write
  always_comb
  begin
    next_result_high_byte = result_high_byte;
    next_result_low_byte = result_low_byte;
    if (wr_result_high)
    begin
      next_result_high_byte = sfr_wdata_i;
    end
    if (wr_result_low)
    begin
      next_result_low_byte = sfr_wdata_i;
    end
    if (cap_valid)
    begin
      next_result_high_byte = fmt_link.word[arfwd_pkg::WORD_W-1:arfwd_pkg::BYTE_W];
      next_result_low_byte = fmt_link.word[arfwd_pkg::BYTE_W-1:0];
    end
  end

  // Result byte state
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      result_high_byte <= arfwd_pkg::RST_RESULT;
      result_low_byte <= arfwd_pkg::RST_RESULT;
    end
    else
    begin
      result_high_byte <= next_result_high_byte;
      result_low_byte <= next_result_low_byte;
    end
  end

  // Read mux; unmapped addresses and unused control bits read zero
  always_comb
  begin
    next_sfr_rdata = sfr_rdata_o;
    if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        arfwd_pkg::ADDR_CONTROL:
        begin
          next_sfr_rdata = arfwd_pkg::READ_UNMAPPED;
          next_sfr_rdata[arfwd_pkg::BIT_LEFT_JUSTIFY] = result_left_justify;
          next_sfr_rdata[arfwd_pkg::BIT_WINDOW_FLAG] = window_compare_flag;
        end
        arfwd_pkg::ADDR_RESULT_HIGH: next_sfr_rdata = result_high_byte;
        arfwd_pkg::ADDR_RESULT_LOW: next_sfr_rdata = result_low_byte;
        arfwd_pkg::ADDR_UPPER_LIMIT_LOW: next_sfr_rdata = window_upper_limit_low;
        arfwd_pkg::ADDR_UPPER_LIMIT_HIGH: next_sfr_rdata = window_upper_limit_high;
        arfwd_pkg::ADDR_LOWER_LIMIT_LOW: next_sfr_rdata = window_lower_limit_low;
        arfwd_pkg::ADDR_LOWER_LIMIT_HIGH: next_sfr_rdata = window_lower_limit_high;
        default: next_sfr_rdata = arfwd_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // Status outputs register the next control state, so they match the control state in the same cycle
  always_comb
  begin
    next_window_compare_flag_o = next_window_compare_flag;
    next_result_left_justify_o = next_result_left_justify;
  end

  // Output registers
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sfr_rdata_o <= arfwd_pkg::READ_UNMAPPED;
      window_compare_flag_o <= arfwd_pkg::RST_WINDOW_FLAG;
      result_left_justify_o <= arfwd_pkg::RST_LEFT_JUSTIFY;
    end
    else
    begin
      sfr_rdata_o <= next_sfr_rdata;
      window_compare_flag_o <= next_window_compare_flag_o;
      result_left_justify_o <= next_result_left_justify_o;
    end
  end

endmodule // arfwd_top

// ---- verif/arfwd_top_monitor.sv ----
// Concurrent checks on the result formatter and window detector ports.
// Assumes one clock, mclk_i, and a synchronous active-high reset_i.
`timescale 1ns/100ps
module arfwd_top_monitor (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  // Converter side
  input wire logic conv_done_i,
  input wire logic [arfwd_pkg::CODE_W-1:0] conv_code_i,
  input wire logic conv_differential_i,
  // Status
  input wire logic window_compare_flag_o,
  input wire logic result_left_justify_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // Control register write decode and mapped read addresses
  wire logic ctl_wr = sfr_wr_i && sfr_addr_i == arfwd_pkg::ADDR_CONTROL;
  wire logic set_wr = ctl_wr && sfr_wdata_i[1];
  wire logic clr_wr = ctl_wr && !sfr_wdata_i[1];
  wire logic mapped = sfr_addr_i inside {8'hE8, 8'hBF, 8'hBE, 8'hC4, 8'hC5, 8'hC6, 8'hC7};

  // Reset, flag, justify select and read data
  a_reset_clears_state: assert property (@(posedge mclk_i) disable iff (1'b0)
    reset_i |=> !window_compare_flag_o && !result_left_justify_o && sfr_rdata_o == 8'h00)
    else $error("state not cleared by reset");
  a_flag_stays_set: assert property (window_compare_flag_o && !clr_wr |=> window_compare_flag_o)
    else $error("window flag dropped without a clear");
  a_flag_rise_cause: assert property ($rose(window_compare_flag_o) |->
    $past(conv_done_i, 2) || $past(set_wr))
    else $error("window flag rose without a conversion");
  a_flag_soft_clear: assert property (clr_wr && !$past(conv_done_i) |=> !window_compare_flag_o)
    else $error("window flag not cleared by write");
  a_justify_write: assert property (ctl_wr |=> result_left_justify_o == $past(sfr_wdata_i[0]))
    else $error("justify select not taken from write");
  a_justify_hold: assert property (!ctl_wr |=> $stable(result_left_justify_o))
    else $error("justify select changed without write");
  a_read_control: assert property (sfr_rd_i && sfr_addr_i == arfwd_pkg::ADDR_CONTROL |=>
    sfr_rdata_o == {6'h00, $past(window_compare_flag_o), $past(result_left_justify_o)})
    else $error("control read does not show flag and select");
  a_read_unmapped: assert property (sfr_rd_i && !mapped |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without a read");

  // Main scenarios
  c_flag_rise: cover property ($rose(window_compare_flag_o));
  c_left_select: cover property (ctl_wr && sfr_wdata_i[0]);
  c_diff_conv: cover property (conv_done_i && conv_differential_i);
  c_clear_collision: cover property (clr_wr && $past(conv_done_i));
endmodule // arfwd_top_monitor

bind arfwd_top arfwd_top_monitor i_arfwd_top_monitor (.mclk_i, .reset_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .conv_done_i, .conv_code_i, .conv_differential_i,
  .window_compare_flag_o, .result_left_justify_o);

// ---- verif/arfwd_top_tb.sv ----
// Self-checking bench for the result formatter and window detector.
// Assumes the register map and one-cycle strobes of the design package.
`timescale 1ns/100ps
module arfwd_top_tb;
  logic mclk_i, reset_i, sfr_wr_i, sfr_rd_i, conv_done_i, conv_differential_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [arfwd_pkg::CODE_W-1:0] conv_code_i;
  logic window_compare_flag_o, result_left_justify_o;
  int n_mismatch = 0;
  int total_checks = 0;

  arfwd_top i_arfwd_top (.mclk_i, .reset_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
    .sfr_rdata_o, .conv_done_i, .conv_code_i, .conv_differential_i, .window_compare_flag_o,
    .result_left_justify_o);

  // Clock
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Compare and count
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register write, one strobe cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge mclk_i);
    #1;
    sfr_wr_i = 1'b0;
  endtask

  // Register read, data checked after the strobe edge
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    #1;
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(posedge mclk_i);
    #1;
    sfr_rd_i = 1'b0;
    chk($sformatf("register %h", a), exp, sfr_rdata_o);
  endtask

  // One end of conversion; returns once results and flag are visible
  task conv(input logic [11:0] c, input logic d);
    @(posedge mclk_i);
    #1;
    conv_code_i = c;
    conv_differential_i = d;
    conv_done_i = 1'b1;
    @(posedge mclk_i);
    #1;
    conv_done_i = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask

  task chk_flag(input logic e);
    chk("window flag", {7'h00, e}, {7'h00, window_compare_flag_o});
  endtask

  // Formatting case under the reset limits, which never hit
  task fmt(input logic j, input logic [11:0] c, input logic d, input logic [7:0] hi, lo);
    wr(8'hE8, {7'h00, j});
    conv(c, d);
    rd(8'hBF, hi);
    rd(8'hBE, lo);
    chk_flag(1'b0);
  endtask

  // Window case: limits, select (clears flag), conversion, flag
  task win(input logic [15:0] lt, gt, input logic j, input logic [11:0] c, input logic d, e);
    wr(8'hC7, lt[15:8]);
    wr(8'hC6, lt[7:0]);
    wr(8'hC5, gt[15:8]);
    wr(8'hC4, gt[7:0]);
    wr(8'hE8, {7'h00, j});
    chk("justify", {7'h00, j}, {7'h00, result_left_justify_o});
    conv(c, d);
    chk_flag(e);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #100000;
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    {sfr_wr_i, sfr_rd_i, conv_done_i, conv_differential_i} = 4'h0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    conv_code_i = 12'h000;
    repeat (8) @(posedge mclk_i);
    #1;
    reset_i = 1'b0;
    rd(8'hC4, 8'hFF);
    rd(8'hC5, 8'hFF);
    rd(8'hC7, 8'h00);
    rd(8'hC6, 8'h00);
    rd(8'hBF, 8'h00);
    rd(8'hBE, 8'h00);
    rd(8'hE8, 8'h00);
    rd(8'h55, 8'h00);
    fmt(1'b0, 12'hABC, 1'b0, 8'h0A, 8'hBC);
    fmt(1'b0, 12'hABC, 1'b1, 8'hFA, 8'hBC);
    fmt(1'b0, 12'h7FF, 1'b1, 8'h07, 8'hFF);
    fmt(1'b0, 12'h800, 1'b1, 8'hF8, 8'h00);
    fmt(1'b1, 12'hABC, 1'b0, 8'hAB, 8'hC0);
    fmt(1'b1, 12'hFFF, 1'b1, 8'hFF, 8'hF0);
    win(16'h0100, 16'hFFFF, 1'b0, 12'h0FF, 1'b0, 1'b1);
    win(16'h0100, 16'hFFFF, 1'b0, 12'h100, 1'b0, 1'b0);
    win(16'h0000, 16'h0800, 1'b0, 12'h801, 1'b0, 1'b1);
    win(16'h0000, 16'h0800, 1'b0, 12'h800, 1'b0, 1'b0);
    win(16'h0100, 16'hFFFF, 1'b0, 12'h0FF, 1'b1, 1'b1);
    win(16'h0100, 16'hFFFF, 1'b0, 12'hFFF, 1'b1, 1'b0);
    win(16'h0100, 16'hFFFF, 1'b0, 12'h100, 1'b1, 1'b0);
    win(16'hFFFF, 16'h0100, 1'b0, 12'h0FF, 1'b1, 1'b0);
    win(16'hFFFF, 16'h0100, 1'b0, 12'hFFE, 1'b1, 1'b1);
    win(16'h0100, 16'hFFFF, 1'b1, 12'h010, 1'b0, 1'b0);
    win(16'h0100, 16'hFFFF, 1'b1, 12'h00F, 1'b0, 1'b1);
    // Flag holds through a miss, reads back, then clears by write
    conv(12'h010, 1'b0);
    chk_flag(1'b1);
    rd(8'hE8, 8'h03);
    wr(8'hE8, 8'h01);
    chk_flag(1'b0);
    // A hit in the same cycle as a clearing write leaves the flag set
    fork
      conv(12'h00F, 1'b0);
      begin
        @(posedge mclk_i);
        wr(8'hE8, 8'h01);
      end
    join
    chk_flag(1'b1);
    // Software may also set the flag through the control register
    wr(8'hE8, 8'h01);
    chk_flag(1'b0);
    wr(8'hE8, 8'h03);
    chk_flag(1'b1);
    // Limit bytes are read-write, each written then read back
    wr(8'hC5, 8'h5A);
    rd(8'hC5, 8'h5A);
    wr(8'hC4, 8'hA5);
    rd(8'hC4, 8'hA5);
    wr(8'hC7, 8'h3C);
    rd(8'hC7, 8'h3C);
    wr(8'hC6, 8'hC3);
    rd(8'hC6, 8'hC3);
    // Result bytes take software writes when no conversion lands
    wr(8'hBF, 8'h5A);
    rd(8'hBF, 8'h5A);
    wr(8'hBE, 8'hA5);
    rd(8'hBE, 8'hA5);
    wr(8'h55, 8'hAA);
    rd(8'h55, 8'h00);
    end_of_test();
  end
endmodule // arfwd_top_tb
